// File: rtl/param_store_map.vh
// object indices, field positions, reset values and codes of the parameter store
`ifndef PARAM_STORE_MAP_VH
`define PARAM_STORE_MAP_VH
`define IDX_CONTROL_METHOD_SELECT 16'h3010
`define IDX_PERSIST_WRITES_GATE   16'h332F
`define IDX_OPTION_BYTE           16'h3500
`define IDX_FAULT_STATUS          16'h3501
`define SUBIDX_MAIN               8'h00
`define METHOD_SPEED_EXPRESS      8'h00
`define METHOD_SPEED              8'h01
`define METHOD_TORQUE             8'h02
`define METHOD_MAX                8'h02
`define RST_CONTROL_METHOD        8'h00
`define RST_PERSIST_GATE          8'h00
`define RST_OPTION_BYTE           8'h00
`define FAULT_CODE_SETTING_CHANGE 8'h31
`define BITS_PER_BYTE             4'h8
`define DIR_RECEIVE               1'b0
`define DIR_TRANSMIT              1'b1
`define ABORT_NO_OBJECT           2'h1
`define ABORT_VALUE_RANGE         2'h2
`define ABORT_READ_ONLY           2'h3
`endif

// File: rtl/persist_commit.v
// commit of changed parameters to non-volatile memory while the gate is open
`timescale 1ns/100ps
module persist_commit (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        change_pulse,
  input  wire [15:0] change_index,
  input  wire [7:0]  change_value,
  input  wire [7:0]  gate_value,
  input  wire        nvm_ready,
  output reg         nvm_write,
  output reg  [15:0] nvm_index,
  output reg  [7:0]  nvm_data,
  output wire        commit_busy
);
  // ************************************************
  // pending commit, launched at most once per change
  // ************************************************
  reg pending_reg;
  assign commit_busy = pending_reg;
  // a change is queued only while the gate is non-zero; closing the gate does not cancel a commit already pending
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= 1'b0;
      nvm_write   <= 1'b0;
      nvm_index   <= 16'h0000;
      nvm_data    <= 8'h00;
    end else begin
      nvm_write <= 1'b0;
      if (change_pulse && (gate_value != 8'h00)) begin
        pending_reg <= 1'b1;
        nvm_index   <= change_index;
        nvm_data    <= change_value;
      end else if (pending_reg && nvm_ready) begin
        nvm_write   <= 1'b1;
        pending_reg <= 1'b0;
      end
    end
  end
endmodule // persist_commit

// File: rtl/param_store_mode_select.v
// parameter store: persist gate, control-method selector and setting-change fault
// Function
// - every bit setting is also one position of a containing byte of eight bits
// - with the persist gate non-zero each selector and option change is queued for commit to nvm
// - changes made while the gate is zero need not survive a key cycle
// - master-to-slave is receive direction, slave-to-master is transmit direction
// - control-method selector takes 0 express speed, 1 speed, 2 torque
// - any change of the selector sets the setting-change fault, code 49
// - the setting-change fault stays latched until power is cycled
`timescale 1ns/100ps
`include "param_store_map.vh"
module param_store_mode_select (
  input  wire        clk,
  input  wire        nrst,
  input  wire        sdo_req,
  input  wire        sdo_write,
  input  wire [15:0] sdo_index,
  input  wire [7:0]  sdo_subindex,
  input  wire [7:0]  sdo_wdata,
  output reg         sdo_ack,
  output reg  [1:0]  sdo_abort,
  output reg  [7:0]  sdo_rdata,
  output reg         sdo_dir,
  input  wire        nvm_ready,
  output wire        nvm_write,
  output wire [15:0] nvm_index,
  output wire [7:0]  nvm_data,
  output wire        nvm_busy,
  output wire [1:0]  control_method,
  output wire        setting_fault,
  output wire [7:0]  fault_code,
  output wire [7:0]  option_bits,
  input  wire        motor_driving
);
  // ************************************************
  // usage notes
  // ************************************************
  // motor_driving is advisory only: keeping the selector still while the
  // motor runs is up to the master, so such writes are neither blocked nor flagged
  // one commit slot only: a change arriving while an earlier commit still waits
  // for nvm_ready replaces it, so the master spaces its changes apart
  // gate writes are never committed, and the gate comes up closed after reset
  // a selector write of the value already held is accepted without a fault
  // a refused selector write leaves both the value and the fault latch alone

  // ************************************************
  // reset release
  // ************************************************
  // nrst is the power-on reset; it is the only thing that clears the fault latch
  // only the second stage feeds the design, so release never lands mid-edge
  reg rst_meta_reg;
  reg rst_n_reg;
  // asynchronous assert, two-stage synchronous release
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ************************************************
  // object storage
  // ************************************************
  reg [7:0] method_reg;
  reg [7:0] gate_reg;
  reg [7:0] option_reg;
  reg       fault_reg;
  reg       change_reg;
  reg [15:0] change_idx_reg;
  reg [7:0] change_val_reg;

  // subindex 0 selects the main value of each object
  function is_obj;
    input [15:0] idx;
    input [7:0]  sub;
    input [15:0] want;
    begin
      is_obj = (idx == want) && (sub == `SUBIDX_MAIN);
    end
  endfunction

  wire hit_method = is_obj(sdo_index, sdo_subindex, `IDX_CONTROL_METHOD_SELECT);
  wire hit_gate   = is_obj(sdo_index, sdo_subindex, `IDX_PERSIST_WRITES_GATE);
  wire hit_option = is_obj(sdo_index, sdo_subindex, `IDX_OPTION_BYTE);
  // bit sub-indices 1..8 reach single bits of the option byte
  wire hit_bit    = (sdo_index == `IDX_OPTION_BYTE) && (sdo_subindex != 8'h00)
                    && (sdo_subindex <= {4'h0, `BITS_PER_BYTE});
  // sub-index 8 wraps to bit 7 through the 3-bit subtraction
  wire [2:0] bit_pos = sdo_subindex[2:0] - 3'h1;
  wire hit_fault  = is_obj(sdo_index, sdo_subindex, `IDX_FAULT_STATUS);

  // ************************************************
  // helper functions
  // ************************************************
  // byte with one bit position replaced, for bit-object writes and their commit
  function [7:0] with_bit;
    input [7:0] byte_in;
    input [2:0] pos;
    input       val;
    reg   [7:0] mask;
    begin
      mask     = 8'h01 << pos;
      with_bit = val ? (byte_in | mask) : (byte_in & ~mask);
    end
  endfunction

  // fault status byte as read back and as shown on fault_code
  function [7:0] fault_report;
    input latched;
    begin
      fault_report = latched ? `FAULT_CODE_SETTING_CHANGE : 8'h00;
    end
  endfunction

  // selector values above the torque method are refused
  function method_ok;
    input [7:0] val;
    begin
      method_ok = (val <= `METHOD_MAX);
    end
  endfunction

  // ************************************************
  // sdo request handling
  // ************************************************
  // every request answered in the following cycle; answer is transmit direction
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      method_reg     <= `RST_CONTROL_METHOD;
      gate_reg       <= `RST_PERSIST_GATE;
      option_reg     <= `RST_OPTION_BYTE;
      fault_reg      <= 1'b0;
      change_reg     <= 1'b0;
      change_idx_reg <= 16'h0000;
      change_val_reg <= 8'h00;
      sdo_ack        <= 1'b0;
      sdo_abort      <= 2'h0;
      sdo_rdata      <= 8'h00;
      sdo_dir        <= `DIR_RECEIVE;
    end else begin
      sdo_ack    <= 1'b0;
      change_reg <= 1'b0;
      if (sdo_req) begin
        sdo_ack   <= 1'b1;
        sdo_dir   <= `DIR_TRANSMIT;
        sdo_abort <= 2'h0;
        sdo_rdata <= 8'h00;
        // writes: refuse, store, and queue a commit for every stored object but the gate
        if (sdo_write) begin
          if (hit_method) begin
            if (!method_ok(sdo_wdata)) begin
              sdo_abort <= `ABORT_VALUE_RANGE;
            end else begin
              method_reg <= sdo_wdata;
              change_reg <= 1'b1;
              change_idx_reg <= `IDX_CONTROL_METHOD_SELECT;
              change_val_reg <= sdo_wdata;
              if (sdo_wdata != method_reg) begin
                fault_reg <= 1'b1;
              end
            end
          end else if (hit_gate) begin
            gate_reg <= sdo_wdata;
          end else if (hit_option) begin
            option_reg     <= sdo_wdata;
            change_reg     <= 1'b1;
            change_idx_reg <= `IDX_OPTION_BYTE;
            change_val_reg <= sdo_wdata;
          end else if (hit_bit) begin
            option_reg     <= with_bit(option_reg, bit_pos, sdo_wdata[0]);
            change_reg     <= 1'b1;
            change_idx_reg <= `IDX_OPTION_BYTE;
            change_val_reg <= with_bit(option_reg, bit_pos, sdo_wdata[0]);
          end else if (hit_fault) begin
            sdo_abort <= `ABORT_READ_ONLY;
          end else begin
            sdo_abort <= `ABORT_NO_OBJECT;
          end
        // reads: return the stored value, bit objects in bit 0
        end else begin
          if (hit_method) begin
            sdo_rdata <= method_reg;
          end else if (hit_gate) begin
            sdo_rdata <= gate_reg;
          end else if (hit_option) begin
            sdo_rdata <= option_reg;
          end else if (hit_bit) begin
            sdo_rdata <= {7'h00, option_reg[bit_pos]};
          end else if (hit_fault) begin
            sdo_rdata <= fault_report(fault_reg);
          end else begin
            sdo_abort <= `ABORT_NO_OBJECT;
          end
        end
      end
    end
  end

  // ************************************************
  // outputs and nvm commit
  // ************************************************
  assign control_method = method_reg[1:0];
  assign setting_fault  = fault_reg;
  assign fault_code     = fault_report(fault_reg);
  assign option_bits    = option_reg;

  persist_commit u_commit (
    .clk          (clk),
    .rst_n        (rst_n_reg),
    .change_pulse (change_reg),
    .change_index (change_idx_reg),
    .change_value (change_val_reg),
    .gate_value   (gate_reg),
    .nvm_ready    (nvm_ready),
    .nvm_write    (nvm_write),
    .nvm_index    (nvm_index),
    .nvm_data     (nvm_data),
    .commit_busy  (nvm_busy)
  );
endmodule // param_store_mode_select

// File: dv/param_store_checker.sv
// port assertions of the parameter store
`timescale 1ns/100ps
module param_store_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        sdo_req,
  input wire logic        sdo_write,
  input wire logic [15:0] sdo_index,
  input wire logic [7:0]  sdo_subindex,
  input wire logic [7:0]  sdo_wdata,
  input wire logic        sdo_ack,
  input wire logic [1:0]  sdo_abort,
  input wire logic        sdo_dir,
  input wire logic        nvm_ready,
  input wire logic        nvm_write,
  input wire logic        nvm_busy,
  input wire logic [1:0]  control_method,
  input wire logic        setting_fault,
  input wire logic [7:0]  fault_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // selector write request
  wire sel_wr = sdo_req && sdo_write && sdo_index == 16'h3010 && sdo_subindex == 8'h00;
  ack_one_cycle_a: assert property (sdo_ack == $past(sdo_req))
    else $error("answer not one cycle after request");
  dir_transmit_a: assert property (sdo_ack |-> sdo_dir)
    else $error("answer not labelled transmit");
  fault_held_a: assert property (setting_fault |=> setting_fault)
    else $error("fault cleared without power cycle");
  fault_cause_a: assert property ($rose(setting_fault) |->
    $past(sel_wr) && $changed(control_method))
    else $error("fault raised without selector change");
  fault_code_a: assert property (fault_code == (setting_fault ? 8'h31 : 8'h00))
    else $error("fault code wrong");
  method_range_a: assert property (control_method <= 2'h2)
    else $error("method out of range");
  method_take_a: assert property (sel_wr && sdo_wdata <= 8'h02 |=>
    control_method == $past(sdo_wdata[1:0]) && sdo_abort == 2'h0)
    else $error("method write not taken");
  over_range_a: assert property (sel_wr && sdo_wdata > 8'h02 |=>
    sdo_abort == 2'h2 && $stable(control_method) && $stable(setting_fault))
    else $error("over-range write not refused");
  commit_pulse_a: assert property (nvm_busy && nvm_ready |=> nvm_write)
    else $error("commit not issued");
  commit_cause_a: assert property (nvm_write |-> $past(nvm_busy))
    else $error("commit without pending change");
endmodule // param_store_checker
bind param_store_mode_select param_store_checker param_store_checker_inst (.clk, .nrst,
  .sdo_req, .sdo_write, .sdo_index, .sdo_subindex, .sdo_wdata, .sdo_ack, .sdo_abort, .sdo_dir,
  .nvm_ready, .nvm_write, .nvm_busy, .control_method, .setting_fault, .fault_code);

// File: dv/nvm_model.sv
// non-volatile memory model: accepts commits promptly or slowly and counts them
`timescale 1ns/100ps
module nvm_model (
  input  wire logic clk,
  input  wire logic slow,
  input  wire logic nvm_write,
  output logic      nvm_ready,
  output int        commits
);
  logic [1:0] ph_reg    = 2'h0;
  int         count_reg = 0;
  // slow mode offers a write slot one cycle in four
  always @(posedge clk) begin
    ph_reg <= ph_reg + 2'h1;
    if (nvm_write) count_reg <= count_reg + 1;
  end
  assign nvm_ready = !slow || ph_reg == 2'h3;
  assign commits   = count_reg;
endmodule // nvm_model

// File: dv/param_store_mode_select_tb.sv
// self-checking bench of the parameter store
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module param_store_mode_select_tb;
  logic        clk = 0, nrst = 0, sdo_req = 0, sdo_write = 0, slow = 0, motor_driving = 0;
  logic [15:0] sdo_index = 16'h0000;
  logic [15:0] idx [4] = '{16'h3010, 16'h332F, 16'h3500, 16'h3501};
  logic [7:0]  sdo_subindex = 8'h00, sdo_wdata = 8'h00, rd, opt;
  wire         sdo_ack, sdo_dir, nvm_ready, nvm_write, nvm_busy, setting_fault;
  wire  [1:0]  sdo_abort, control_method;
  wire  [7:0]  sdo_rdata, nvm_data, fault_code, option_bits;
  wire  [15:0] nvm_index;
  int          errors = 0, cmp_count = 0, seed = 32'h8577, commits, n;
  param_store_mode_select param_store_mode_select_inst (.clk, .nrst, .sdo_req, .sdo_write,
    .sdo_index, .sdo_subindex, .sdo_wdata, .sdo_ack, .sdo_abort, .sdo_rdata, .sdo_dir,
    .nvm_ready, .nvm_write, .nvm_index, .nvm_data, .nvm_busy, .control_method,
    .setting_fault, .fault_code, .option_bits, .motor_driving);
  nvm_model nvm_model_inst (.clk, .slow, .nvm_write, .nvm_ready, .commits);
  initial forever #2.5 clk = ~clk;
  // expected refusal code of one request
  function automatic logic [1:0] exp_abort(input logic [15:0] i, input logic w,
                                            input logic [7:0] s, d);
    if (i == 16'h3500 && s >= 8'h01 && s <= 8'h08) return 2'h0;
    if (s != 8'h00) return 2'h1;
    if (i == 16'h3501) return w ? 2'h3 : 2'h0;
    if (i == 16'h3010 && w && d > 8'h02) return 2'h2;
    return (i == 16'h3010 || i == 16'h332F || i == 16'h3500) ? 2'h0 : 2'h1;
  endfunction
  // one request, answer checked one cycle after it is driven, just after the edge that takes it
  task automatic sdo(input logic w, input logic [15:0] i, input logic [7:0] s, d);
    @(posedge clk) #1;
    {sdo_req, sdo_write, sdo_index, sdo_subindex, sdo_wdata} = {1'b1, w, i, s, d};
    @(posedge clk) #1;
    sdo_req = 1'b0;
    rd = sdo_rdata;
    `CHK(sdo_ack, 1'b1)
    `CHK(sdo_dir, 1'b1)
    `CHK(sdo_abort, exp_abort(i, w, s, d))
  endtask
  // wait for pending commits, then compare the count
  task automatic drain(input int exp);
    @(posedge clk) #1;
    n = 0;
    while (nvm_busy !== 1'b0 && n < 40) begin
      @(posedge clk) #1;
      n++;
    end
    // the write pulse of the last commit is counted one edge after busy drops
    @(posedge clk) #1;
    `CHK(n < 40, 1'b1)
    `CHK(commits, exp)
  endtask
  task automatic conclude;
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    conclude;
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 nrst = 1;
    repeat (3) @(posedge clk);
    foreach (idx[k]) begin
      sdo(1'b0, idx[k], 8'h00, 8'h00);
      `CHK(rd, 8'h00)
    end
    // corner cases with the gate closed: refused, unchanged value, bad sub-index
    sdo(1'b1, 16'h3010, 8'h00, 8'h03);
    sdo(1'b1, 16'h3010, 8'h00, 8'h00);
    `CHK(setting_fault, 1'b0)
    sdo(1'b0, 16'h3010, 8'h01, 8'h00);
    sdo(1'b0, 16'h3500, 8'h09, 8'h00);
    drain(0);
    sdo(1'b1, 16'h332F, 8'h00, 8'h01 | 8'($random(seed)));
    for (int k = 1; k < 7; k++) begin
      slow = k[0];
      sdo(1'b1, 16'h3010, 8'h00, 8'(k % 3));
      `CHK(control_method, 2'(k % 3))
      `CHK(setting_fault, 1'b1)
      drain(k);
      `CHK(nvm_index, 16'h3010)
      `CHK(nvm_data, 8'(k % 3))
    end
    sdo(1'b1, 16'h3010, 8'h00, 8'h03);
    sdo(1'b1, 16'h3010, 8'h00, 8'h80 | 8'($random(seed)));
    `CHK(control_method, 2'h0)
    drain(6);
    opt = 8'($random(seed));
    sdo(1'b1, 16'h3500, 8'h00, opt);
    drain(7);
    `CHK(nvm_data, opt)
    for (int k = 1; k < 9; k++) begin
      motor_driving = 1'($random(seed));
      sdo(1'b0, 16'h3500, 8'(k), 8'h00);
      `CHK(rd, {7'h00, opt[k-1]})
    end
    motor_driving = 1'b0;
    sdo(1'b1, 16'h3500, 8'h08, {7'h00, ~opt[7]});
    drain(8);
    `CHK(option_bits, {~opt[7], opt[6:0]})
    `CHK(nvm_data, {~opt[7], opt[6:0]})
    sdo(1'b0, 16'h3501, 8'h00, 8'h00);
    `CHK(rd, 8'h31)
    `CHK(fault_code, 8'h31)
    sdo(1'b1, 16'h3501, 8'h00, 8'h00);
    sdo(1'b1, 16'h1234, 8'h00, 8'h00);
    sdo(1'b1, 16'h332F, 8'h00, 8'h00);
    sdo(1'b1, 16'h3010, 8'h00, 8'h01);
    drain(8);
    nrst = 0;
    @(posedge clk) #1 nrst = 1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(setting_fault, 1'b0)
    `CHK(fault_code, 8'h00)
    `CHK(control_method, 2'h0)
    `CHK(sdo_dir, 1'b0)
    conclude;
  end
endmodule // param_store_mode_select_tb
